// ===== inc/asw_pkg.sv
`default_nettype none
package asw_pkg;
	// word geometry
	localparam int unsigned STAT_W          = 16;
	localparam int unsigned POS_W           = 8;
	localparam int unsigned TABLE_DEPTH     = 256;
	localparam int unsigned TABLE_AW        = 8;
	localparam logic [15:0] POS16_MAX       = 16'h000F;

	// eight-bit mode status word layout
	localparam int unsigned EMERGENCY_STOP_BIT = 15;
	localparam int unsigned ZONE_ONE_BIT       = 14;
	localparam int unsigned PUSH_MISS_BIT      = 13;
	localparam int unsigned SERVO_READY_BIT    = 12;
	localparam int unsigned ALARM_BIT          = 11;
	localparam int unsigned IN_MOTION_BIT      = 10;
	localparam int unsigned HOMED_BIT          = 9;
	localparam int unsigned POS_DONE_BIT       = 8;
	localparam int unsigned COMPLETED_POS_MSB  = 7;
	localparam int unsigned COMPLETED_POS_LSB  = 0;

	// sixteen-point mode status word layout
	localparam int unsigned S16_EMERGENCY_STOP_BIT = 15;
	localparam int unsigned S16_ZONE_TWO_BIT       = 13;
	localparam int unsigned S16_ZONE_ONE_BIT       = 12;
	localparam int unsigned S16_COMPLETED_POS_MSB  = 11;
	localparam int unsigned S16_COMPLETED_POS_LSB  = 8;
	localparam int unsigned S16_PUSH_MISS_BIT      = 5;
	localparam int unsigned S16_SERVO_READY_BIT    = 4;
	localparam int unsigned S16_ALARM_BIT          = 3;
	localparam int unsigned S16_IN_MOTION_BIT      = 2;
	localparam int unsigned S16_HOMED_BIT          = 1;
	localparam int unsigned S16_POS_DONE_BIT       = 0;

	// reset values
	localparam logic [15:0] STATUS_WORD_RST   = 16'h0000;
	localparam logic [15:0] POSITION_WORD_RST = 16'h0000;
	localparam logic [7:0]  COMPLETED_POS_RST = 8'h00;

	// alarm codes
	localparam logic [11:0] ALARM_CODE_NONE           = 12'h000;
	localparam logic [11:0] ALARM_CODE_POS_DATA_ERROR = 12'h0A2;

	typedef enum logic [1:0] {
		MODE_POS8  = 2'b01,
		MODE_POS16 = 2'b10
	} asw_mode_t;

	typedef enum logic [2:0] {
		CMD_IDLE = 3'b001,
		CMD_LOOK = 3'b010,
		CMD_JUDGE = 3'b100
	} asw_cmd_state_t;
endpackage : asw_pkg
`default_nettype wire

// ===== src/asw_sync.sv
`timescale 1ns/1ps
`default_nettype none
module asw_sync #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk_sys_i,
	input  wire logic         resetn_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);
	import asw_pkg::*;

	logic [W-1:0] stage1_reg;
	logic [W-1:0] stage2_reg;

	// two flops per bit
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			always_ff @(posedge clk_sys_i or negedge resetn_i) begin
				if (!resetn_i) begin
					stage1_reg[g] <= 1'b0;
					stage2_reg[g] <= 1'b0;
				end else begin
					stage1_reg[g] <= async_i[g];
					stage2_reg[g] <= stage1_reg[g];
				end
			end
		end
	endgenerate

	assign sync_o = stage2_reg;
endmodule : asw_sync
`default_nettype wire

// ===== src/asw_pos_table.sv
`timescale 1ns/1ps
`default_nettype none
module asw_pos_table (
	input  wire logic                          clk_sys_i,
	input  wire logic                          resetn_i,
	input  wire logic                          wr_en_i,
	input  wire logic [asw_pkg::TABLE_AW-1:0]  wr_addr_i,
	input  wire logic                          wr_data_i,
	input  wire logic [asw_pkg::TABLE_AW-1:0]  rd_addr_i,
	output logic                               rd_data_o
);
	import asw_pkg::*;

	logic [TABLE_DEPTH-1:0] entry_reg;

	// configured marks, all cleared at reset
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			entry_reg <= '0;
		end else if (wr_en_i) begin
			entry_reg[wr_addr_i] <= wr_data_i;
		end
	end

	// registered read
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rd_data_o <= 1'b0;
		end else begin
			rd_data_o <= entry_reg[rd_addr_i];
		end
	end
endmodule : asw_pos_table
`default_nettype wire

// ===== src/asw_status_word.sv
`timescale 1ns/1ps
`default_nettype none
module asw_status_word (
	input  wire logic                         clk_sys_i,
	input  wire logic                         resetn_i,
	input  wire asw_pkg::asw_mode_t           mode_i,
	input  wire logic                         emergency_stop_pin_i,
	input  wire logic                         alarm_pin_i,
	input  wire logic                         servo_on_pin_i,
	input  wire logic                         push_contact_pin_i,
	input  wire logic signed [15:0]           cur_pos_i,
	input  wire logic signed [15:0]           zone_one_flag_lo_i,
	input  wire logic signed [15:0]           zone_one_flag_hi_i,
	input  wire logic signed [15:0]           target_pos_i,
	input  wire logic        [15:0]           pos_width_i,
	input  wire logic                         move_start_i,
	input  wire logic                         move_end_i,
	input  wire logic                         push_op_i,
	input  wire logic                         home_done_i,
	input  wire logic                         home_lost_i,
	input  wire logic                         alarm_reset_i,
	input  wire logic        [15:0]           cmd_word_i,
	input  wire logic                         cmd_strobe_i,
	input  wire logic                         cfg_we_i,
	input  wire logic [asw_pkg::TABLE_AW-1:0] cfg_addr_i,
	input  wire logic                         cfg_valid_i,
	output logic             [15:0]           status_word_o,
	output logic             [15:0]           position_word_o,
	output logic [asw_pkg::TABLE_AW-1:0]      sel_pos_o,
	output logic                              sel_pos_valid_o,
	output logic                              pos_data_error_o,
	output logic             [11:0]           alarm_code_o
);
	import asw_pkg::*;

	// position field of the command word for the active mode
	function automatic logic [TABLE_AW-1:0] pos_field(input logic [15:0] word, input asw_mode_t mode);
		logic [TABLE_AW-1:0] f;
		f = '0;
		if (mode == MODE_POS16) begin
			f = word[TABLE_AW-1:0];
		end else begin
			f = word[COMPLETED_POS_MSB:COMPLETED_POS_LSB];
		end
		return f;
	endfunction : pos_field

	// range check of the command word for the active mode
	function automatic logic pos_in_range(input logic [15:0] word, input asw_mode_t mode);
		logic ok;
		ok = 1'b0;
		if (mode == MODE_POS16) begin
			ok = (word <= POS16_MAX);
		end else begin
			ok = (mode == MODE_POS8);
		end
		return ok;
	endfunction : pos_in_range

	// synchronised pins
	logic [3:0]                  pin_raw;
	logic [3:0]                  pin_sync;
	logic                        emergency_stop_flag_sync;
	logic                        alarm_sync;
	logic                        servo_sync;
	logic                        contact_sync;

	// command checking
	asw_cmd_state_t              cmd_state_reg;
	asw_cmd_state_t              cmd_state_next;
	logic [15:0]                 cmd_word_reg;
	logic [TABLE_AW-1:0]         table_rd_addr;
	logic                        table_rd_data;
	logic                        cmd_ok;
	logic                        cmd_bad;

	// axis state
	logic                        moving_reg;
	logic                        push_miss_reg;
	logic                        homed_reg;
	logic                        pos_done_reg;
	logic                        pos_err_reg;
	logic [TABLE_AW-1:0]         pending_pos_reg;
	logic [POS_W-1:0]            completed_pos_reg;
	logic [POS_W-1:0]            completed_pos_next;
	logic signed [16:0]          pos_diff;
	logic        [16:0]          pos_dist;
	logic                        in_window;
	logic                        in_zone_one;
	logic                        push_failed;
	logic                        move_success;
	logic                        alarm_now;
	logic                        servo_ready;

	// status words
	logic [15:0]                 status_word_next;
	logic [15:0]                 position_word_next;

	assign pin_raw = {push_contact_pin_i, servo_on_pin_i, alarm_pin_i, emergency_stop_pin_i};

	asw_sync #(
		.W (4)
	) u_pin_sync (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.async_i   (pin_raw),
		.sync_o    (pin_sync)
	);

	assign emergency_stop_flag_sync    = pin_sync[0];
	assign alarm_sync   = pin_sync[1];
	assign servo_sync   = pin_sync[2];
	assign contact_sync = pin_sync[3];

	assign table_rd_addr = pos_field(cmd_word_reg, mode_i);

	asw_pos_table u_pos_table (
		.clk_sys_i (clk_sys_i),
		.resetn_i  (resetn_i),
		.wr_en_i   (cfg_we_i),
		.wr_addr_i (cfg_addr_i),
		.wr_data_i (cfg_valid_i),
		.rd_addr_i (table_rd_addr),
		.rd_data_o (table_rd_data)
	);

	// command word capture, plain binary position field
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_word_reg <= 16'h0000;
		end else if (cmd_strobe_i && cmd_state_reg == CMD_IDLE) begin
			cmd_word_reg <= cmd_word_i;
		end
	end

	// verdict on the looked-up entry
	assign cmd_ok  = (cmd_state_reg == CMD_JUDGE) && pos_in_range(cmd_word_reg, mode_i)
		&& table_rd_data;
	assign cmd_bad = (cmd_state_reg == CMD_JUDGE) && !cmd_ok;

	always_comb begin
		cmd_state_next = cmd_state_reg;
		unique case (cmd_state_reg)
			CMD_IDLE: begin
				if (cmd_strobe_i) begin
					cmd_state_next = CMD_LOOK;
				end
			end
			CMD_LOOK: begin
				cmd_state_next = CMD_JUDGE;
			end
			CMD_JUDGE: begin
				cmd_state_next = CMD_IDLE;
			end
			default: begin
				cmd_state_next = CMD_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cmd_state_reg <= CMD_IDLE;
		end else begin
			cmd_state_reg <= cmd_state_next;
		end
	end

	// accepted selection towards the motion logic; the table entry only marks the number as configured
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sel_pos_o       <= '0;
			sel_pos_valid_o <= 1'b0;
		end else begin
			sel_pos_valid_o <= cmd_ok;
			if (cmd_ok) begin
				sel_pos_o <= table_rd_addr;
			end
		end
	end

	// position data error alarm, set wins over reset request
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pos_err_reg <= 1'b0;
		end else if (cmd_bad) begin
			pos_err_reg <= 1'b1;
		end else if (alarm_reset_i) begin
			pos_err_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			alarm_code_o     <= ALARM_CODE_NONE;
			pos_data_error_o <= 1'b0;
		end else begin
			pos_data_error_o <= pos_err_reg || cmd_bad;
			alarm_code_o     <= (pos_err_reg || cmd_bad) ? ALARM_CODE_POS_DATA_ERROR : ALARM_CODE_NONE;
		end
	end

	assign alarm_now = alarm_sync || pos_err_reg;

	// positioning window and zone tests
	assign pos_diff = 17'(cur_pos_i) - 17'(target_pos_i);
	assign pos_dist = pos_diff[16] ? 17'(-pos_diff) : 17'(pos_diff);
	assign in_window = (pos_dist <= {1'b0, pos_width_i});
	assign in_zone_one = (cur_pos_i >= zone_one_flag_lo_i) && (cur_pos_i <= zone_one_flag_hi_i);

	assign push_failed  = move_end_i && push_op_i && !contact_sync;
	assign move_success = move_end_i && in_window && !push_failed;

	// motion tracking
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			moving_reg <= 1'b0;
		end else if (move_start_i) begin
			moving_reg <= 1'b1;
		end else if (move_end_i) begin
			moving_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pending_pos_reg <= '0;
		end else if (cmd_ok) begin
			pending_pos_reg <= table_rd_addr;
		end
	end

	// push miss, set wins over the clear at next start
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			push_miss_reg <= 1'b0;
		end else if (push_failed) begin
			push_miss_reg <= 1'b1;
		end else if (move_start_i) begin
			push_miss_reg <= 1'b0;
		end
	end

	// homed reference
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			homed_reg <= 1'b0;
		end else if (home_done_i) begin
			homed_reg <= 1'b1;
		end else if (home_lost_i || alarm_now) begin
			homed_reg <= 1'b0;
		end
	end

	// positioning done, held while stopped with servo on
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pos_done_reg <= 1'b0;
		end else if (move_success && servo_sync) begin
			pos_done_reg <= 1'b1;
		end else if (move_start_i || !servo_sync || push_failed) begin
			pos_done_reg <= 1'b0;
		end
	end

	// completed position number
	always_comb begin
		completed_pos_next = completed_pos_reg;
		if (move_success && servo_sync) begin
			completed_pos_next = pending_pos_reg;
		end else if (move_start_i) begin
			completed_pos_next = COMPLETED_POS_RST;
		end
	end

	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			completed_pos_reg <= COMPLETED_POS_RST;
		end else begin
			completed_pos_reg <= completed_pos_next;
		end
	end

	assign servo_ready = servo_sync && !emergency_stop_flag_sync;

	// word assembly for both modes
	always_comb begin
		status_word_next   = STATUS_WORD_RST;
		position_word_next = POSITION_WORD_RST;
		if (mode_i == MODE_POS16) begin
			position_word_next = cur_pos_i;
			status_word_next[S16_EMERGENCY_STOP_BIT] = emergency_stop_flag_sync;
			status_word_next[S16_ZONE_TWO_BIT]       = 1'b0;
			status_word_next[S16_ZONE_ONE_BIT]       = in_zone_one;
			status_word_next[S16_COMPLETED_POS_MSB:S16_COMPLETED_POS_LSB] =
				moving_reg ? 4'h0 : completed_pos_reg[3:0];
			status_word_next[S16_PUSH_MISS_BIT]      = push_miss_reg;
			status_word_next[S16_SERVO_READY_BIT]    = servo_ready;
			status_word_next[S16_ALARM_BIT]          = alarm_now;
			status_word_next[S16_IN_MOTION_BIT]      = moving_reg;
			status_word_next[S16_HOMED_BIT]          = homed_reg;
			status_word_next[S16_POS_DONE_BIT]       = pos_done_reg;
		end else begin
			status_word_next[EMERGENCY_STOP_BIT] = emergency_stop_flag_sync;
			status_word_next[ZONE_ONE_BIT]       = in_zone_one;
			status_word_next[PUSH_MISS_BIT]      = push_miss_reg;
			status_word_next[SERVO_READY_BIT]    = servo_ready;
			status_word_next[ALARM_BIT]          = alarm_now;
			status_word_next[IN_MOTION_BIT]      = moving_reg;
			status_word_next[HOMED_BIT]          = homed_reg;
			status_word_next[POS_DONE_BIT]       = pos_done_reg;
			status_word_next[COMPLETED_POS_MSB:COMPLETED_POS_LSB] =
				moving_reg ? COMPLETED_POS_RST : completed_pos_reg;
		end
	end

	// one register for the whole word pair
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			status_word_o   <= STATUS_WORD_RST;
			position_word_o <= POSITION_WORD_RST;
		end else begin
			status_word_o   <= status_word_next;
			position_word_o <= position_word_next;
		end
	end
endmodule : asw_status_word
`default_nettype wire

// ===== tb/asw_status_word_props.sv
`timescale 1ns/1ps
`default_nettype none
module asw_chk (
	input wire logic                         clk_sys_i,
	input wire logic                         resetn_i,
	input wire asw_pkg::asw_mode_t           mode_i,
	input wire logic                         emergency_stop_pin_i,
	input wire logic                         move_start_i,
	input wire logic                         cmd_strobe_i,
	input wire logic signed [15:0]           cur_pos_i,
	input wire logic signed [15:0]           zone_one_flag_lo_i,
	input wire logic signed [15:0]           zone_one_flag_hi_i,
	input wire logic        [15:0]           status_word_o,
	input wire logic        [15:0]           position_word_o,
	input wire logic [asw_pkg::TABLE_AW-1:0] sel_pos_o,
	input wire logic                         sel_pos_valid_o,
	input wire logic                         pos_data_error_o,
	input wire logic        [11:0]           alarm_code_o
);
	import asw_pkg::*;
	logic [2:0] up_reg;
	logic       p8;
	assign p8 = (mode_i == MODE_POS8);
	// cycles since reset release, saturating
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			up_reg <= 3'h0;
		end else if (up_reg != 3'h7) begin
			up_reg <= up_reg + 3'h1;
		end
	end
	default clocking dc @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	sequence s_start;
		move_start_i && p8;
	endsequence
	sequence s_moving;
		##2 status_word_o[10] && status_word_o[7:0] == 8'h00;
	endsequence
	AST_MOVE_CLEARS: assert property (s_start |-> s_moving)
		else $error("moving flag or number wrong after start");
	AST_ESTOP: assert property (up_reg == 3'h7 |-> status_word_o[15] == $past(emergency_stop_pin_i, 3))
		else $error("emergency flag does not follow pin");
	AST_CODE: assert property (alarm_code_o == (pos_data_error_o ? 12'h0A2 : 12'h000))
		else $error("alarm code does not match error");
	AST_SEL_CAUSE: assert property (sel_pos_valid_o |-> $past(cmd_strobe_i, 3))
		else $error("acceptance without request");
	AST_SEL_PULSE: assert property (sel_pos_valid_o |=> !sel_pos_valid_o)
		else $error("acceptance pulse too long");
	AST_S16_RANGE: assert property (sel_pos_valid_o && !p8 |-> sel_pos_o <= 8'h0F)
		else $error("number above fifteen accepted");
	AST_IDLE_NUM: assert property (p8 && $stable(mode_i) && status_word_o[10] |-> status_word_o[8:0] == 9'h000)
		else $error("done or number shown while moving");
	AST_ZONE: assert property (p8 && $stable(mode_i) && up_reg == 3'h7 |->
		status_word_o[14] == $past(zone_one_flag_lo_i <= cur_pos_i && cur_pos_i <= zone_one_flag_hi_i))
		else $error("zone flag wrong");
	AST_POSWORD: assert property (up_reg == 3'h7 |->
		position_word_o == ($past(mode_i) == MODE_POS16 ? $past(cur_pos_i) : 16'h0000))
		else $error("position word wrong");
	AST_ALM: assert property ($rose(pos_data_error_o) && p8 && $stable(mode_i) |-> ##[0:2] status_word_o[11])
		else $error("alarm flag missing on data error");
	AST_S16_ZERO: assert property (!p8 && $stable(mode_i) |-> status_word_o[14:13] == 2'h0 && status_word_o[7:6] == 2'h0)
		else $error("unused bits set in sixteen point word");
endmodule : asw_chk
bind asw_status_word asw_chk u_chk (.clk_sys_i, .resetn_i, .mode_i, .emergency_stop_pin_i, .move_start_i,
	.cmd_strobe_i, .cur_pos_i, .zone_one_flag_lo_i, .zone_one_flag_hi_i, .status_word_o, .position_word_o, .sel_pos_o,
	.sel_pos_valid_o, .pos_data_error_o, .alarm_code_o);
`default_nettype wire

// ===== tb/asw_plc_model.sv
`timescale 1ns/1ps
`default_nettype none
module asw_plc_model (
	input  wire logic        clk_sys_i,
	input  wire logic [15:0] status_word_i,
	output logic      [15:0] cmd_word_o,
	output logic             cmd_strobe_o
);
	import asw_pkg::*;
	initial begin
		cmd_word_o = 16'h0000;
		cmd_strobe_o = 1'b0;
	end
	// one request, then keep the three cycle spacing
	task automatic request(input logic [15:0] num);
		@(posedge clk_sys_i);
		cmd_word_o <= num;
		cmd_strobe_o <= 1'b1;
		@(posedge clk_sys_i);
		cmd_strobe_o <= 1'b0;
		cmd_word_o <= ~num;
		repeat (2) @(posedge clk_sys_i);
	endtask : request
	// completed number read only once done is up
	task automatic read_done(output logic [7:0] num);
		num = 'x;
		for (int i = 0; i < 20; i++) begin
			@(posedge clk_sys_i);
			if (status_word_i[POS_DONE_BIT] === 1'b1) begin
				num = status_word_i[COMPLETED_POS_MSB:0];
				break;
			end
		end
	endtask : read_done
endmodule : asw_plc_model
`default_nettype wire

// ===== tb/test_axis_status_word_map.sv
`timescale 1ns/1ps
`default_nettype none
module test_axis_status_word_map;
	import asw_pkg::*;
	typedef struct packed {logic err; logic [7:0] num;} asw_exp_t;
	asw_exp_t           exq[$];
	asw_exp_t           e;
	asw_mode_t          mode_i = MODE_POS8;
	logic               clk_sys_i = 1'b0, resetn_i = 1'b0, emergency_stop_pin_i = 1'b0, alarm_pin_i = 1'b0;
	logic               servo_on_pin_i = 1'b1, push_contact_pin_i = 1'b0, move_start_i = 1'b0, move_end_i = 1'b0;
	logic               push_op_i = 1'b0, home_done_i = 1'b0, home_lost_i = 1'b0, alarm_reset_i = 1'b0;
	logic               cfg_we_i = 1'b0, cfg_valid_i = 1'b0, err_seen = 1'b0;
	logic               cmd_strobe_i, sel_pos_valid_o, pos_data_error_o;
	logic signed [15:0] cur_pos_i = 16'h0028, zone_one_flag_lo_i = 16'h0028, zone_one_flag_hi_i = 16'h002A, target_pos_i = 16'h0028;
	logic        [15:0] pos_width_i = 16'h0002, cmd_word_i, status_word_o, position_word_o, last_pos;
	logic        [7:0]  cfg_addr_i = 8'h00, sel_pos_o, got;
	logic        [11:0] alarm_code_o;
	logic               tbl [256];
	int                 seed = 32'h09B0BB6B;
	int                 errors = 0, n_checks = 0;

	always #4 clk_sys_i = ~clk_sys_i;

	asw_plc_model plc (.clk_sys_i, .status_word_i(status_word_o), .cmd_word_o(cmd_word_i), .cmd_strobe_o(cmd_strobe_i));
	asw_status_word dut (.clk_sys_i, .resetn_i, .mode_i, .emergency_stop_pin_i, .alarm_pin_i, .servo_on_pin_i,
		.push_contact_pin_i, .cur_pos_i, .zone_one_flag_lo_i, .zone_one_flag_hi_i, .target_pos_i, .pos_width_i, .move_start_i,
		.move_end_i, .push_op_i, .home_done_i, .home_lost_i, .alarm_reset_i, .cmd_word_i, .cmd_strobe_i, .cfg_we_i,
		.cfg_addr_i, .cfg_valid_i, .status_word_o, .position_word_o, .sel_pos_o, .sel_pos_valid_o,
		.pos_data_error_o, .alarm_code_o);

	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task automatic report_and_stop();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	task automatic settle(input int n);
		repeat (n) @(posedge clk_sys_i);
		@(negedge clk_sys_i);
	endtask : settle

	// note the verdict, ask, then clear any data error
	task automatic req(input logic [15:0] w);
		logic bad;
		bad = (mode_i == MODE_POS16) ? (w > POS16_MAX || !tbl[w[7:0]]) : !tbl[w[7:0]];
		exq.push_back('{bad, w[7:0]});
		plc.request(w);
		repeat (2) @(posedge clk_sys_i);
		alarm_reset_i <= bad;
		@(posedge clk_sys_i);
		alarm_reset_i <= 1'b0;
	endtask : req

	task automatic move(input logic [15:0] endpos, input logic push);
		@(posedge clk_sys_i);
		push_op_i <= push;
		move_start_i <= 1'b1;
		@(posedge clk_sys_i);
		move_start_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		cur_pos_i <= endpos;
		move_end_i <= 1'b1;
		@(posedge clk_sys_i);
		move_end_i <= 1'b0;
		settle(2);
	endtask : move

	// result watcher
	always @(posedge clk_sys_i) begin
		err_seen <= pos_data_error_o;
		if (sel_pos_valid_o === 1'b1 || (pos_data_error_o === 1'b1 && !err_seen)) begin
			check("result queued", {15'h0000, exq.size() == 0}, 16'h0000);
			e = exq.size() ? exq.pop_front() : 9'h1FF;
			check("result", {pos_data_error_o, sel_pos_valid_o ? sel_pos_o : 8'h00},
				{e.err, e.err ? 8'h00 : e.num});
			check("alarm code", alarm_code_o, e.err ? ALARM_CODE_POS_DATA_ERROR : ALARM_CODE_NONE);
		end
	end

	initial begin
		repeat (5000) @(posedge clk_sys_i);
		errors++;
		report_and_stop();
	end

	initial begin
		repeat (8) @(posedge clk_sys_i);
		check("reset status", status_word_o, STATUS_WORD_RST);
		check("reset position", position_word_o, POSITION_WORD_RST);
		resetn_i <= 1'b1;
		for (int i = 0; i < 256; i++) begin
			tbl[i] = (i < 16) ? (i != 7) : ((i == 18) | 1'($random(seed)));
			@(posedge clk_sys_i);
			cfg_we_i <= 1'b1;
			cfg_addr_i <= 8'(i);
			cfg_valid_i <= tbl[i];
		end
		@(posedge clk_sys_i);
		cfg_we_i <= 1'b0;
		req(16'h0007);
		req(16'h00C8);
		req(16'($random(seed)));
		req(16'hAB05);
		move(16'h0029, 1'b0);
		plc.read_done(got);
		check("done number", got, 8'h05);
		check("upper flags", status_word_o[15:8], 8'h51);
		move(16'h0029, 1'b1);
		check("push miss", status_word_o[15:8], 8'h70);
		@(posedge clk_sys_i);
		push_contact_pin_i <= 1'b1;
		move(16'h002B, 1'b0);
		check("outside window", status_word_o[15:8], 8'h10);
		@(posedge clk_sys_i);
		home_done_i <= 1'b1;
		@(posedge clk_sys_i);
		home_done_i <= 1'b0;
		settle(2);
		check("homed", status_word_o[9], 1'b1);
		@(posedge clk_sys_i);
		home_lost_i <= 1'b1;
		settle(2);
		check("home lost", status_word_o[9], 1'b0);
		@(posedge clk_sys_i);
		home_lost_i <= 1'b0;
		home_done_i <= 1'b1;
		@(posedge clk_sys_i);
		home_done_i <= 1'b0;
		settle(2);
		check("rehomed", status_word_o[9], 1'b1);
		@(posedge clk_sys_i);
		alarm_pin_i <= 1'b1;
		settle(5);
		check("alarm", status_word_o[11:9], 3'b100);
		@(posedge clk_sys_i);
		alarm_pin_i <= 1'b0;
		emergency_stop_pin_i <= 1'b1;
		settle(5);
		check("estop", {status_word_o[15], status_word_o[12]}, 2'b10);
		@(posedge clk_sys_i);
		emergency_stop_pin_i <= 1'b0;
		mode_i <= MODE_POS16;
		settle(4);
		req(16'h0012);
		req(16'h0100);
		req(16'h0007);
		req(16'h0003);
		move(16'h0029, 1'b0);
		check("s16 status", {status_word_o[11:8], status_word_o[0]}, 5'h07);
		check("s16 position", position_word_o, 16'h0029);
		@(posedge clk_sys_i);
		last_pos = {1'b1, 15'($random(seed))};
		cur_pos_i <= last_pos;
		settle(2);
		check("negative position", position_word_o, last_pos);
		check("pending", 16'(exq.size()), 16'h0000);
		report_and_stop();
	end
endmodule : test_axis_status_word_map
`default_nettype wire
